//--- core/prox_regs.svh
`ifndef PROX_REGS_SVH
`define PROX_REGS_SVH

// Command codes of the sensor-side registers
`define CMD_MODE_CONFIG    8'h02
`define CMD_LOW_THRESH     8'h03
`define CMD_HIGH_THRESH    8'h04

// Fields of the mode configuration register
`define MODE_BIT           4
`define TRIG_BIT           5
`define FAST_LSB           14
`define FAST_MSB           15
`define SUNC_LSB           10
`define SUNC_MSB           12
`define CONF3_RESET        16'h0000
`define CONF3_DEFINED_MASK 16'hDC30
`define THRESH_RESET       16'h0000
`define SUNC_ON            3'h7
`define SUNC_OFF           3'h0
`define FAST_NORMAL        2'h0
`define FAST_6MS           2'h1
`define FAST_12MS          2'h2
`define FAST_25MS          2'h3

// Timing
`define CLK_PERIOD_NS      20
`define FAST1_MS           6.25
`define FAST2_MS           12.5
`define FAST3_MS           25
`define NORMAL_MS          100

// Controller register map (byte offsets)
`define HOST_CMD_OFS       12'h000
`define HOST_WDATA_OFS     12'h004
`define HOST_RDATA_OFS     12'h008
`define HOST_STATUS_OFS    12'h00C
`define HOST_MASK_OFS      12'h010
`define CMDREG_WRITE_BIT   8
`define CMDREG_GO_BIT      31
`define RDREG_BUSY_BIT     16
`define ST_DONE            0
`define ST_CLOSE           1
`define ST_AWAY            2
`define ST_RESET           3'h0

`endif

//--- core/prox_link_pkg.sv
`default_nettype none
package prox_link_pkg;
	typedef enum logic {H_IDLE = 1'b0, H_WAIT = 1'b1} host_state_t;
	typedef enum logic {M_IDLE = 1'b0, M_RUN = 1'b1} meas_state_t;
endpackage
`default_nettype wire

//--- core/prox_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface prox_link_if;
	logic        req;         // Host request, held until ack
	logic        we;          // Write when high
	logic [7:0]  cmd;         // Command code
	logic [15:0] wdata;       // Write data
	logic        ack;         // One-cycle answer
	logic [15:0] rdata;       // Read data, valid with ack
	logic        close_state; // Last result above high threshold
	logic        away_state;  // Last result below low threshold

	modport dev (input req, we, cmd, wdata, output ack, rdata, close_state, away_state);
	modport host (output req, we, cmd, wdata, input ack, rdata, close_state, away_state);
endinterface
`default_nettype wire

//--- core/interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "prox_regs.svh"
module interval_timer #(
	parameter int FAST1_CYC  = 312500,
	parameter int FAST2_CYC  = 625000,
	parameter int FAST3_CYC  = 1250000,
	parameter int NORMAL_CYC = 5000000
) (
	input  wire logic       pclk,    // Clock
	input  wire logic       presetn, // Async reset, active low
	input  wire logic       run,     // Count while high
	input  wire logic [1:0] sel,     // Interval code
	output logic            tick     // One-cycle pulse per interval
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;
	logic [31:0] limit;

	always_comb
	begin
		unique case (sel)
			`FAST_6MS:  limit = 32'(FAST1_CYC - 1);
			`FAST_12MS: limit = 32'(FAST2_CYC - 1);
			`FAST_25MS: limit = 32'(FAST3_CYC - 1);
			default:    limit = 32'(NORMAL_CYC - 1);
		endcase
		nxt_tick = 1'b0;
		if (!run)
			nxt_cnt = 32'h00000000;
		else if (cnt_ff >= limit)
		begin
			// >= so a shortened interval chosen mid-count still fires
			nxt_cnt  = 32'h00000000;
			nxt_tick = 1'b1;
		end
		else
			nxt_cnt = cnt_ff + 32'h00000001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff  <= 32'h00000000;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

//--- core/prox_sensor_end.sv
`timescale 1ns/1ns
`default_nettype none
`include "prox_regs.svh"
module prox_sensor_end #(
	parameter int FAST1_CYC  = int'(`FAST1_MS * 1.0e6 / `CLK_PERIOD_NS),
	parameter int FAST2_CYC  = int'(`FAST2_MS * 1.0e6 / `CLK_PERIOD_NS),
	parameter int FAST3_CYC  = int'(`FAST3_MS * 1.0e6 / `CLK_PERIOD_NS),
	parameter int NORMAL_CYC = int'(`NORMAL_MS * 1.0e6 / `CLK_PERIOD_NS)
) (
	input  wire logic        pclk,               // Clock
	input  wire logic        presetn,            // Async reset, active low
	prox_link_if.dev         link,               // Register link from the host
	output logic             meas_start,         // Pulse: begin one measurement
	input  wire logic        meas_done,          // Pulse: measurement finished
	input  wire logic [15:0] meas_result,        // Result, valid with meas_done
	output logic             sunlight_cancel_en, // Sunlight cancellation active
	output logic             close_flag,         // Result above high threshold
	output logic             away_flag           // Result below low threshold
);
	logic                      scheme_ff;
	logic                      nxt_scheme;
	logic                      trig_ff;
	logic                      nxt_trig;
	logic [1:0]                fast_ff;
	logic [1:0]                nxt_fast;
	logic [2:0]                sunc_ff;
	logic [2:0]                nxt_sunc;
	logic [15:0]               low_ff;
	logic [15:0]               nxt_low;
	logic [15:0]               high_ff;
	logic [15:0]               nxt_high;

	logic                      ack_ff;
	logic                      nxt_ack;
	logic [15:0]               rdata_ff;
	logic [15:0]               nxt_rdata;

	prox_link_pkg::meas_state_t state_ff;
	prox_link_pkg::meas_state_t nxt_state;
	logic                      forced_ff;
	logic                      nxt_forced;
	logic                      start_ff;
	logic                      nxt_start;
	logic                      close_ff;
	logic                      nxt_close;
	logic                      away_ff;
	logic                      nxt_away;
	logic                      sunc_en_ff;
	logic                      nxt_sunc_en;

	logic                      take;
	logic                      wr_hit;
	logic                      tick;
	logic                      timer_run;

	assign take      = link.req & ~ack_ff;
	assign wr_hit    = take & link.we;
	assign timer_run = ~scheme_ff;

	interval_timer #(
		.FAST1_CYC  (FAST1_CYC),
		.FAST2_CYC  (FAST2_CYC),
		.FAST3_CYC  (FAST3_CYC),
		.NORMAL_CYC (NORMAL_CYC)
	) interval_timer_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (timer_run),
		.sel     (fast_ff),
		.tick    (tick)
	);

	// Register writes and readback
	always_comb
	begin
		nxt_scheme = scheme_ff;
		nxt_trig   = trig_ff;
		nxt_fast   = fast_ff;
		nxt_sunc   = sunc_ff;
		nxt_low    = low_ff;
		nxt_high   = high_ff;
		nxt_ack    = take;
		nxt_rdata  = rdata_ff;
		// Clear first so that a trigger written in the same cycle wins
		if (state_ff == prox_link_pkg::M_RUN && meas_done && forced_ff)
			nxt_trig = 1'b0;
		if (wr_hit)
		begin
			unique case (link.cmd)
				`CMD_MODE_CONFIG:
				begin
					// Reserved bits are not stored and read back as zero
					nxt_scheme = link.wdata[`MODE_BIT];
					nxt_trig   = link.wdata[`TRIG_BIT];
					nxt_fast   = link.wdata[`FAST_MSB:`FAST_LSB];
					nxt_sunc   = link.wdata[`SUNC_MSB:`SUNC_LSB];
				end
				`CMD_LOW_THRESH:  nxt_low  = link.wdata;
				`CMD_HIGH_THRESH: nxt_high = link.wdata;
				default:          nxt_low  = low_ff;
			endcase
		end
		if (take && !link.we)
		begin
			unique case (link.cmd)
				`CMD_MODE_CONFIG:
				begin
					nxt_rdata                      = 16'h0000;
					nxt_rdata[`MODE_BIT]           = scheme_ff;
					nxt_rdata[`TRIG_BIT]           = trig_ff;
					nxt_rdata[`FAST_MSB:`FAST_LSB] = fast_ff;
					nxt_rdata[`SUNC_MSB:`SUNC_LSB] = sunc_ff;
				end
				`CMD_LOW_THRESH:  nxt_rdata = low_ff;
				`CMD_HIGH_THRESH: nxt_rdata = high_ff;
				default:          nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scheme_ff <= 1'b0;
			trig_ff   <= 1'b0;
			fast_ff   <= `FAST_NORMAL;
			sunc_ff   <= `SUNC_OFF;
			low_ff    <= `THRESH_RESET;
			high_ff   <= `THRESH_RESET;
			ack_ff    <= 1'b0;
			rdata_ff  <= 16'h0000;
		end
		else
		begin
			scheme_ff <= nxt_scheme;
			trig_ff   <= nxt_trig;
			fast_ff   <= nxt_fast;
			sunc_ff   <= nxt_sunc;
			low_ff    <= nxt_low;
			high_ff   <= nxt_high;
			ack_ff    <= nxt_ack;
			rdata_ff  <= nxt_rdata;
		end
	end

	// Measurement sequencing and threshold compare
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_forced  = forced_ff;
		nxt_start   = 1'b0;
		nxt_close   = close_ff;
		nxt_away    = away_ff;
		// Only the exact enable code switches cancellation on
		nxt_sunc_en = (sunc_ff == `SUNC_ON);
		unique case (state_ff)
			prox_link_pkg::M_IDLE:
			begin
				if (scheme_ff && trig_ff)
				begin
					nxt_state  = prox_link_pkg::M_RUN;
					nxt_forced = 1'b1;
					nxt_start  = 1'b1;
				end
				else if (!scheme_ff && tick)
				begin
					nxt_state  = prox_link_pkg::M_RUN;
					nxt_forced = 1'b0;
					nxt_start  = 1'b1;
				end
			end
			prox_link_pkg::M_RUN:
			begin
				// A tick that lands mid-measurement is dropped, not queued
				if (meas_done)
				begin
					nxt_state = prox_link_pkg::M_IDLE;
					nxt_close = (meas_result > high_ff);
					nxt_away  = (meas_result < low_ff);
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff   <= prox_link_pkg::M_IDLE;
			forced_ff  <= 1'b0;
			start_ff   <= 1'b0;
			close_ff   <= 1'b0;
			away_ff    <= 1'b0;
			sunc_en_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			forced_ff  <= nxt_forced;
			start_ff   <= nxt_start;
			close_ff   <= nxt_close;
			away_ff    <= nxt_away;
			sunc_en_ff <= nxt_sunc_en;
		end
	end

	assign link.ack           = ack_ff;
	assign link.rdata         = rdata_ff;
	assign link.close_state   = close_ff;
	assign link.away_state    = away_ff;
	assign meas_start         = start_ff;
	assign sunlight_cancel_en = sunc_en_ff;
	assign close_flag         = close_ff;
	assign away_flag          = away_ff;
endmodule
`default_nettype wire

//--- core/prox_host_end.sv
`timescale 1ns/1ns
`default_nettype none
`include "prox_regs.svh"
module prox_host_end (
	input  wire logic        pclk,    // Clock
	input  wire logic        presetn, // Async reset, active low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB write
	input  wire logic [11:0] paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error on unmapped address
	output logic             irq,     // Level interrupt
	prox_link_if.host        link     // Register link to the sensor
);
	prox_link_pkg::host_state_t state_ff;
	prox_link_pkg::host_state_t nxt_state;
	logic [7:0]  cmd_ff, nxt_cmd;
	logic        wr_ff, nxt_wr;
	logic [15:0] wdata_ff, nxt_wdata;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [2:0]  status_ff, nxt_status;
	logic [2:0]  mask_ff, nxt_mask;
	logic        req_ff, nxt_req;
	logic        lwe_ff, nxt_lwe;
	logic [7:0]  lcmd_ff, nxt_lcmd;
	logic [15:0] lwd_ff, nxt_lwd;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        irq_ff, nxt_irq;
	logic        close_q_ff, away_q_ff;
	logic        done_ev;
	logic        wr_acc;
	logic        go;
	logic        mapped;
	logic [15:0] clean;
	logic [2:0]  set_bits;
	logic [2:0]  clr_bits;

	assign wr_acc = psel & penable & pready_ff & pwrite;
	assign go     = wr_acc && paddr == `HOST_CMD_OFS && pwdata[`CMDREG_GO_BIT]
	                && state_ff == prox_link_pkg::H_IDLE;
	assign mapped = paddr == `HOST_CMD_OFS || paddr == `HOST_WDATA_OFS
	                || paddr == `HOST_RDATA_OFS || paddr == `HOST_STATUS_OFS
	                || paddr == `HOST_MASK_OFS;
	assign done_ev = state_ff == prox_link_pkg::H_WAIT && link.ack;

	always_comb
	begin
		// Reserved config bits forced to zero before they leave
		clean = wdata_ff;
		if (pwdata[7:0] == `CMD_MODE_CONFIG)
		begin
			clean = wdata_ff & `CONF3_DEFINED_MASK;
			if (clean[`SUNC_MSB:`SUNC_LSB] != `SUNC_ON)
				clean[`SUNC_MSB:`SUNC_LSB] = `SUNC_OFF;
		end
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cmd   = cmd_ff;
		nxt_wr    = wr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_mask  = mask_ff;
		nxt_req   = req_ff;
		nxt_lwe   = lwe_ff;
		nxt_lcmd  = lcmd_ff;
		nxt_lwd   = lwd_ff;
		set_bits  = 3'h0;
		clr_bits  = 3'h0;
		if (wr_acc && paddr == `HOST_CMD_OFS)
		begin
			nxt_cmd = pwdata[7:0];
			nxt_wr  = pwdata[`CMDREG_WRITE_BIT];
		end
		if (wr_acc && paddr == `HOST_WDATA_OFS)
			nxt_wdata = pwdata[15:0];
		if (wr_acc && paddr == `HOST_MASK_OFS)
			nxt_mask = pwdata[2:0];
		if (wr_acc && paddr == `HOST_STATUS_OFS)
			clr_bits = pwdata[2:0];
		if (go)
		begin
			nxt_state = prox_link_pkg::H_WAIT;
			nxt_req   = 1'b1;
			nxt_lwe   = pwdata[`CMDREG_WRITE_BIT];
			nxt_lcmd  = pwdata[7:0];
			nxt_lwd   = clean;
		end
		if (done_ev)
		begin
			nxt_state = prox_link_pkg::H_IDLE;
			nxt_req   = 1'b0;
			nxt_rdata = link.rdata;
		end
		set_bits[`ST_DONE]  = done_ev;
		set_bits[`ST_CLOSE] = link.close_state & ~close_q_ff;
		set_bits[`ST_AWAY]  = link.away_state & ~away_q_ff;
		// Set wins over a simultaneous write-one clear
		nxt_status = (status_ff & ~clr_bits) | set_bits;
		nxt_irq    = |(status_ff & mask_ff);
		nxt_pready  = psel & penable & ~pready_ff;
		nxt_pslverr = nxt_pready & ~mapped;
		nxt_prdata  = 32'h00000000;
		if (nxt_pready && !pwrite)
		begin
			unique case (paddr)
				`HOST_CMD_OFS:    nxt_prdata = {23'h000000, wr_ff, cmd_ff};
				`HOST_WDATA_OFS:  nxt_prdata = {16'h0000, wdata_ff};
				`HOST_RDATA_OFS:  nxt_prdata = {15'h0000, state_ff == prox_link_pkg::H_WAIT,
				                                rdata_ff};
				`HOST_STATUS_OFS: nxt_prdata = {29'h00000000, status_ff};
				`HOST_MASK_OFS:   nxt_prdata = {29'h00000000, mask_ff};
				default:          nxt_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff   <= prox_link_pkg::H_IDLE;
			cmd_ff     <= 8'h00;
			wr_ff      <= 1'b0;
			wdata_ff   <= 16'h0000;
			rdata_ff   <= 16'h0000;
			status_ff  <= `ST_RESET;
			mask_ff    <= 3'h0;
			req_ff     <= 1'b0;
			lwe_ff     <= 1'b0;
			lcmd_ff    <= 8'h00;
			lwd_ff     <= 16'h0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
			irq_ff     <= 1'b0;
			close_q_ff <= 1'b0;
			away_q_ff  <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cmd_ff     <= nxt_cmd;
			wr_ff      <= nxt_wr;
			wdata_ff   <= nxt_wdata;
			rdata_ff   <= nxt_rdata;
			status_ff  <= nxt_status;
			mask_ff    <= nxt_mask;
			req_ff     <= nxt_req;
			lwe_ff     <= nxt_lwe;
			lcmd_ff    <= nxt_lcmd;
			lwd_ff     <= nxt_lwd;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
			irq_ff     <= nxt_irq;
			close_q_ff <= link.close_state;
			away_q_ff  <= link.away_state;
		end
	end

	assign prdata     = prdata_ff;
	assign pready     = pready_ff;
	assign pslverr    = pslverr_ff;
	assign irq        = irq_ff;
	assign link.req   = req_ff;
	assign link.we    = lwe_ff;
	assign link.cmd   = lcmd_ff;
	assign link.wdata = lwd_ff;
endmodule
`default_nettype wire

//--- testbench/prox_link_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "prox_regs.svh"
module prox_link_props (
	input wire logic        pclk,        // Clock
	input wire logic        presetn,     // Reset, active low
	input wire logic        req,         // Link request
	input wire logic        we,          // Write
	input wire logic [7:0]  cmd,         // Command code
	input wire logic [15:0] wdata,       // Write data
	input wire logic        ack,         // Answer
	input wire logic [15:0] rdata,       // Read data
	input wire logic        close_state, // Above high threshold
	input wire logic        away_state   // Below low threshold
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire cfg_wr = req && we && cmd == `CMD_MODE_CONFIG;

	property p_ack_time; $rose(req) |=> ack; endproperty
	a_ack_time: assert property (p_ack_time)
		else $error("ack not one cycle after request");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_req; ack |-> req; endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("ack without request");
	property p_req_hold; req && !ack |=> req && $stable({we, cmd, wdata}); endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed before ack");
	property p_req_drop; ack |=> !req; endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("request held after ack");
	property p_rdata_hold; $changed(rdata) |-> ack; endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved outside ack");
	// Reserved config bits must leave the host as zero
	property p_cfg_clean; cfg_wr |-> (wdata & ~`CONF3_DEFINED_MASK) == 16'h0000; endproperty
	a_cfg_clean: assert property (p_cfg_clean)
		else $error("reserved config bits written nonzero");
	property p_sunc_legal; cfg_wr |-> wdata[12:10] inside {3'h0, 3'h7}; endproperty
	a_sunc_legal: assert property (p_sunc_legal)
		else $error("illegal sunlight code written");

	c_cfg_wr: cover property (cfg_wr && ack);
	c_read: cover property (req && !we && ack);
	c_close: cover property ($rose(close_state));
	c_away: cover property ($rose(away_state));
endmodule
`default_nettype wire

//--- testbench/proximity_mode_threshold_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "prox_regs.svh"
module proximity_mode_threshold_regs_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        meas_start;
	logic        meas_done = 1'b0;
	logic [15:0] meas_result = 16'h0000;
	logic        sunc_en;
	logic        close_flag;
	logic        away_flag;
	logic [15:0] meas_val = 16'h0000;
	logic [31:0] q;
	logic        q_err;
	logic [15:0] lrd;
	int          resp_delay = 3;
	int          dly = 0;
	int          done_cnt = 0;
	int          start_cnt = 0;
	int          cyc = 0;
	int          err_count = 0;
	int          comparisons = 0;
	int          k;
	int          t0;
	int          d;
	localparam int per_tab [4] = '{160, 20, 40, 80};
	localparam logic [15:0] res_tab [3] = '{16'h00FF, 16'h8000, 16'h0100};
	localparam logic [31:0] flag_tab [3] = '{32'h1, 32'h0, 32'h0};

	always #10 pclk = ~pclk;

	prox_link_if prox_link_if_inst ();
	prox_host_end prox_host_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .link(prox_link_if_inst));
	// Short intervals keep the auto-mode checks to a few hundred cycles
	prox_sensor_end #(.FAST1_CYC(20), .FAST2_CYC(40), .FAST3_CYC(80), .NORMAL_CYC(160))
		prox_sensor_end_inst (.pclk(pclk), .presetn(presetn), .link(prox_link_if_inst),
		.meas_start(meas_start), .meas_done(meas_done), .meas_result(meas_result),
		.sunlight_cancel_en(sunc_en), .close_flag(close_flag), .away_flag(away_flag));
	prox_link_props prox_link_props_inst (.pclk(pclk), .presetn(presetn),
		.req(prox_link_if_inst.req), .we(prox_link_if_inst.we), .cmd(prox_link_if_inst.cmd),
		.wdata(prox_link_if_inst.wdata), .ack(prox_link_if_inst.ack),
		.rdata(prox_link_if_inst.rdata), .close_state(prox_link_if_inst.close_state),
		.away_state(prox_link_if_inst.away_state));

	// Measurement engine stand-in; result bus shows junk outside the done pulse
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (meas_start === 1'b1)
		begin
			start_cnt <= start_cnt + 1;
			dly <= resp_delay;
		end
		else if (dly > 0)
			dly <= dly - 1;
		// One assignment per signal per edge, so no ordering hazard between them
		if (meas_start !== 1'b1 && dly == 1)
		begin
			meas_done <= 1'b1;
			meas_result <= meas_val;
			done_cnt <= done_cnt + 1;
		end
		else
		begin
			meas_done <= 1'b0;
			meas_result <= ~meas_val;
		end
	end

	task automatic complete_run();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic hang();
		err_count++;
		$display("[ERR] %0t wait timed out", $time);
		complete_run();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) hang();
		q = prdata;
		q_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// One link transfer through the controller, polled until it is no longer busy
	task automatic link(input logic w, input logic [7:0] c, input logic [15:0] wd);
		int n;
		apb(1'b1, `HOST_WDATA_OFS, {16'h0000, wd});
		apb(1'b1, `HOST_CMD_OFS, {1'b1, 22'h000000, w, c});
		n = 0;
		do
		begin
			apb(1'b0, `HOST_RDATA_OFS, 32'h00000000);
			n++;
		end
		while (q[16] !== 1'b0 && n < 20);
		if (q[16] !== 1'b0) hang();
		lrd = q[15:0];
		apb(1'b1, `HOST_STATUS_OFS, 32'h00000001);
	endtask

	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		link(1'b0, c, 16'h0000);
		chk({16'h0000, lrd}, {16'h0000, e});
	endtask

	task automatic wdone(input int kk);
		for (int n = 0; n < 300 && done_cnt == kk; n++) @(posedge pclk);
		if (done_cnt == kk) hang();
		@(posedge pclk);
	endtask

	task automatic wstart();
		int kk;
		kk = start_cnt;
		for (int n = 0; n < 400 && start_cnt == kk; n++) @(posedge pclk);
		if (start_cnt == kk) hang();
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`CMD_MODE_CONFIG, 16'h0000);
		rdc(`CMD_LOW_THRESH, 16'h0000);
		rdc(`CMD_HIGH_THRESH, 16'h0000);
		apb(1'b0, 12'h020, 32'h00000000);
		chk({q_err, q[30:0]}, 32'h80000000);
		link(1'b1, `CMD_LOW_THRESH, 16'h0100);
		link(1'b1, `CMD_HIGH_THRESH, 16'h8000);
		apb(1'b0, `HOST_CMD_OFS, 32'h00000000);
		chk(q, 32'h00000104);
		apb(1'b0, `HOST_WDATA_OFS, 32'h00000000);
		chk(q, 32'h00008000);
		rdc(`CMD_LOW_THRESH, 16'h0100);
		rdc(`CMD_HIGH_THRESH, 16'h8000);
		link(1'b1, `CMD_MODE_CONFIG, 16'hC3CF);
		rdc(`CMD_MODE_CONFIG, 16'hC000);
		link(1'b1, `CMD_MODE_CONFIG, 16'h1C00);
		rdc(`CMD_MODE_CONFIG, 16'h1C00);
		chk({31'h0, sunc_en}, 32'h1);
		link(1'b1, `CMD_MODE_CONFIG, 16'h0800);
		rdc(`CMD_MODE_CONFIG, 16'h0000);
		chk({31'h0, sunc_en}, 32'h0);
		link(1'b1, `CMD_MODE_CONFIG, 16'h0010);
		k = start_cnt;
		repeat (400) @(posedge pclk);
		chk(start_cnt, k);
		apb(1'b1, `HOST_STATUS_OFS, 32'h00000007);
		apb(1'b1, `HOST_MASK_OFS, 32'h00000002);
		resp_delay = 100;
		k = done_cnt;
		meas_val = 16'h9000;
		link(1'b1, `CMD_MODE_CONFIG, 16'h0030);
		rdc(`CMD_MODE_CONFIG, 16'h0030);
		wdone(k);
		rdc(`CMD_MODE_CONFIG, 16'h0010);
		resp_delay = 3;
		chk({30'h0, close_flag, away_flag}, 32'h2);
		apb(1'b0, `HOST_STATUS_OFS, 32'h00000000);
		chk(q, 32'h00000002);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `HOST_STATUS_OFS, 32'h00000002);
		apb(1'b0, `HOST_STATUS_OFS, 32'h00000000);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			k = done_cnt;
			meas_val = res_tab[i];
			link(1'b1, `CMD_MODE_CONFIG, 16'h0030);
			wdone(k);
			chk({30'h0, close_flag, away_flag}, flag_tab[i]);
		end
		apb(1'b0, `HOST_STATUS_OFS, 32'h00000000);
		chk(q, 32'h00000004);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			link(1'b1, `CMD_MODE_CONFIG, {i[1:0], 14'h0000});
			rdc(`CMD_MODE_CONFIG, {i[1:0], 14'h0000});
			wstart();
			t0 = cyc;
			wstart();
			d = cyc - t0 - per_tab[i];
			chk({31'h0, d >= -1 && d <= 1}, 32'h1);
		end
		complete_run();
	end

	initial
	begin
		#1200000;
		hang();
	end
endmodule
`default_nettype wire
